// *** logic/ppt_pkg.sv ***
// Summary of operation
// - Address write with read select fetches RAM word.
// - Address write with write select stores data word.
// - Busy rises on address write, falls when done.
// - Data word meaning follows selected RAM page.
// - Enabled checker compares payload; disabled ignores it.
// - Checker invert bit inverts received bytes first.
// - Reacquire bit forces checker out of sync.
// - Checker pattern select: PRBS low, sequential high.
// - LFSR pages load new starting state: checker all 23 bits, generator top 16 only.
// - Error counter counts only while synchronised.
// - Any wrong bits in byte add one.
// - Page write or trigger register copies counter.
// - Counter restarts on copy, losing no error.
// - Error counter saturates at all ones.
// - Generator invert bit inverts inserted bytes.
// - Force-error flips next byte MSB, self clears.
// - Generator pattern select: PRBS low, sequential high.
// - Insert enable replaces payload, else pass through.
// - Path field 1 to 12 valid, others invalid.
// - Page top bit selects checker or generator.
package ppt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_ACC_TRIG = 12'h014;
  localparam logic [11:0] IDX_IND_ADDR = 12'h080;
  localparam logic [11:0] IDX_IND_DATA = 12'h081;
  localparam logic [11:0] IDX_SYNC_STATE = 12'h086;
  // Indirect address fields
  localparam int ADDR_BUSY_BIT = 15;
  localparam int ADDR_RNW_BIT = 14;
  localparam int PAGE_LSB = 6;
  localparam int PATH_LSB = 0;
  // RAM pages
  localparam logic [3:0] PAGE_MON_CFG = 4'h0;
  localparam logic [3:0] PAGE_MON_HI = 4'h1;
  localparam logic [3:0] PAGE_MON_LO = 4'h2;
  localparam logic [3:0] PAGE_MON_ERR = 4'h4;
  localparam logic [3:0] PAGE_GEN_CFG = 4'h8;
  localparam logic [3:0] PAGE_GEN_HI = 4'h9;
  // Configuration page bits
  localparam int MON_EN_BIT = 0;
  localparam int MON_INV_BIT = 2;
  localparam int MON_FORCE_REACQUIRE_BIT = 3;
  localparam int MON_SEQ_BIT = 6;
  localparam int GEN_INV_BIT = 1;
  localparam int GEN_FORCE_BIT = 3;
  localparam int GEN_SEQ_BIT = 5;
  localparam int GEN_INS_LO_BIT = 8;
  localparam int GEN_INS_HI_BIT = 12;
  localparam logic [15:0] MON_CFG_MASK = 16'h0045;
  localparam logic [15:0] GEN_CFG_MASK = 16'h1122;
  // Pattern engine
  localparam int LFSR_W = 23;
  localparam int LFSR_TAP_A = 22;
  localparam int LFSR_TAP_B = 17;
  localparam int LFSR_HI_LSB = 7;
  localparam int LFSR_LO_W = 7;
  localparam logic [7:0] MSB_FLIP = 8'h80;
  localparam logic [2:0] SYNC_MATCH_CNT = 3'h4;
  localparam logic [2:0] SYNC_LOSS_CNT = 3'h4;
  localparam logic [15:0] ERR_MAX = 16'hffff;

  typedef struct packed {
    logic valid;
    logic [3:0] path;
    logic [7:0] data;
  } ppt_byte_t;

  typedef enum logic [1:0] {IND_IDLE = 2'b01, IND_ACCESS = 2'b10} ppt_ind_state_t;
  typedef enum logic [1:0] {MON_HUNT = 2'b01, MON_LOCKED = 2'b10} ppt_mon_state_t;

  // Eight LFSR steps: returns next state and the eight new bits
  function automatic logic [LFSR_W+7:0] ppt_prbs_step(input logic [LFSR_W-1:0] s);
    logic [LFSR_W-1:0] st;
    logic [7:0] b;
    st = s;
    b = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      b = {b[6:0], st[LFSR_TAP_A] ^ st[LFSR_TAP_B]};
      st = {st[LFSR_W-2:0], b[0]};
    end
    return {st, b};
  endfunction
endpackage

// *** logic/ppt_path_test.sv ***
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module ppt_path_test import ppt_pkg::*; #(
  parameter int NUM_PATHS = 12,
  parameter int APB_ADDR_W = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ppt_byte_t rx_byte,
  input wire ppt_byte_t tx_in_byte,
  output ppt_byte_t tx_out_byte,
  output logic [NUM_PATHS-1:0] checker_locked
);
  // Elaboration check
  if (NUM_PATHS < 1 || NUM_PATHS > 15 || APB_ADDR_W < 14)
  begin : g_bad_param
    $error("ppt_path_test: unsupported parameter values");
  end

  ppt_ind_state_t ind_state_reg;
  logic read_not_write_select_reg;
  logic [3:0] ram_page_select_reg;
  logic [3:0] path_select_reg;
  logic [15:0] ind_data_reg;
  logic [15:0] rd_word;
  logic acc_go;
  logic acc_wr;
  logic busy;
  logic apb_wr;
  logic apb_rd;
  logic hit_trig;
  logic hit_addr;
  logic hit_data;
  logic hit_sync;
  logic acc_trig_wr;
  logic [15:0] mon_cfg_reg [NUM_PATHS];
  logic [15:0] gen_cfg_reg [NUM_PATHS];
  logic [LFSR_W-1:0] mon_lfsr_reg [NUM_PATHS];
  logic [LFSR_W-1:0] gen_lfsr_reg [NUM_PATHS];
  logic [15:0] err_live_reg [NUM_PATHS];
  logic [15:0] err_hold_reg [NUM_PATHS];
  logic [7:0] gen_byte [NUM_PATHS];
  logic [NUM_PATHS-1:0] gen_sel;

  // APB decode
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  always_comb
  begin
    hit_trig = 1'b0;
    hit_addr = 1'b0;
    hit_data = 1'b0;
    hit_sync = 1'b0;
    if (paddr[1:0] != 2'b00)
      hit_trig = 1'b0;
    else if (paddr[13:2] == IDX_ACC_TRIG)
      hit_trig = 1'b1;
    else if (paddr[13:2] == IDX_IND_ADDR)
      hit_addr = 1'b1;
    else if (paddr[13:2] == IDX_IND_DATA)
      hit_data = 1'b1;
    else if (paddr[13:2] == IDX_SYNC_STATE)
      hit_sync = 1'b1;
  end
  assign pslverr = psel && penable && !(hit_trig || hit_addr || hit_data || hit_sync);
  assign acc_trig_wr = apb_wr && hit_trig;

  // APB read data
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (apb_rd && hit_addr)
    begin
      prdata[ADDR_BUSY_BIT] = busy;
      prdata[ADDR_RNW_BIT] = read_not_write_select_reg;
      prdata[PAGE_LSB +: 4] = ram_page_select_reg;
      prdata[PATH_LSB +: 4] = path_select_reg;
    end
    else if (apb_rd && hit_data)
      prdata[15:0] = ind_data_reg;
    else if (apb_rd && hit_sync)
      prdata[NUM_PATHS-1:0] = checker_locked;
  end

  // Indirect access sequencer
  assign busy = (ind_state_reg == IND_ACCESS);
  assign acc_go = (ind_state_reg == IND_ACCESS);
  assign acc_wr = acc_go && !read_not_write_select_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ind_state_reg <= IND_IDLE;
      read_not_write_select_reg <= 1'b0;
      ram_page_select_reg <= 4'h0;
      path_select_reg <= 4'h0;
    end
    else
    begin
      case (ind_state_reg)
        IND_IDLE:
        begin
          if (apb_wr && hit_addr)
          begin
            read_not_write_select_reg <= pwdata[ADDR_RNW_BIT];
            ram_page_select_reg <= pwdata[PAGE_LSB +: 4];
            path_select_reg <= pwdata[PATH_LSB +: 4];
            ind_state_reg <= IND_ACCESS;
          end
        end
        IND_ACCESS:
          ind_state_reg <= IND_IDLE;
        default:
          ind_state_reg <= IND_IDLE;
      endcase
    end
  end

  // Indirect data register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ind_data_reg <= 16'h0000;
    else if (acc_go && read_not_write_select_reg)
      ind_data_reg <= rd_word;
    else if (apb_wr && hit_data && !busy)
      ind_data_reg <= pwdata[15:0];
  end

  // RAM read mux by page, invalid paths read zero
  always_comb
  begin
    logic [3:0] idx;
    idx = path_select_reg - 4'h1;
    rd_word = 16'h0000;
    if (path_select_reg != 4'h0 && path_select_reg <= 4'(NUM_PATHS))
    begin
      case (ram_page_select_reg)
        PAGE_MON_CFG: rd_word = mon_cfg_reg[idx];
        PAGE_MON_HI: rd_word = mon_lfsr_reg[idx][LFSR_W-1:LFSR_HI_LSB];
        PAGE_MON_LO: rd_word = {9'h000, mon_lfsr_reg[idx][LFSR_LO_W-1:0]};
        PAGE_MON_ERR: rd_word = err_hold_reg[idx];
        PAGE_GEN_CFG: rd_word = gen_cfg_reg[idx];
        PAGE_GEN_HI: rd_word = gen_lfsr_reg[idx][LFSR_W-1:LFSR_HI_LSB];
        default: rd_word = 16'h0000;
      endcase
    end
  end

  // Per path checker and generator
  for (genvar p = 0; p < NUM_PATHS; p++)
  begin : g_path
    ppt_mon_state_t mon_state_reg;
    logic [2:0] run_reg;
    logic [7:0] mon_cnt_reg;
    logic [7:0] gen_cnt_reg;
    logic force_pend_reg;
    logic sel;
    logic mon_stb;
    logic gen_stb;
    logic mismatch;
    logic err_evt;
    logic xfer;
    logic reacquire;
    logic [7:0] rx_cmp;
    logic [7:0] expect_byte;
    logic [LFSR_W+7:0] mon_step;
    logic [LFSR_W+7:0] gen_step;

    assign sel = acc_wr && (path_select_reg == 4'(p + 1));
    assign mon_step = ppt_prbs_step(mon_lfsr_reg[p]);
    assign gen_step = ppt_prbs_step(gen_lfsr_reg[p]);
    assign mon_stb = rx_byte.valid && rx_byte.path == 4'(p + 1) && mon_cfg_reg[p][MON_EN_BIT];
    assign rx_cmp = rx_byte.data ^ {8{mon_cfg_reg[p][MON_INV_BIT]}};
    assign expect_byte = mon_cfg_reg[p][MON_SEQ_BIT] ? mon_cnt_reg : mon_step[7:0];
    assign mismatch = (rx_cmp != expect_byte);
    assign err_evt = mon_stb && mismatch && (mon_state_reg == MON_LOCKED);
    assign xfer = acc_trig_wr || (sel && ram_page_select_reg == PAGE_MON_ERR);
    assign reacquire = sel && ram_page_select_reg == PAGE_MON_CFG && ind_data_reg[MON_FORCE_REACQUIRE_BIT];
    assign gen_stb = tx_in_byte.valid && tx_in_byte.path == 4'(p + 1)
                     && (gen_cfg_reg[p][GEN_INS_HI_BIT] || gen_cfg_reg[p][GEN_INS_LO_BIT]);
    assign checker_locked[p] = (mon_state_reg == MON_LOCKED);

    // Configuration pages, write-only bits not stored
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        mon_cfg_reg[p] <= 16'h0000;
        gen_cfg_reg[p] <= 16'h0000;
      end
      else if (sel && ram_page_select_reg == PAGE_MON_CFG)
        mon_cfg_reg[p] <= ind_data_reg & MON_CFG_MASK;
      else if (sel && ram_page_select_reg == PAGE_GEN_CFG)
        gen_cfg_reg[p] <= ind_data_reg & GEN_CFG_MASK;
    end

    // Checker sync state machine
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        mon_state_reg <= MON_HUNT;
        run_reg <= 3'h0;
      end
      else if (reacquire)
      begin
        mon_state_reg <= MON_HUNT;
        run_reg <= 3'h0;
      end
      else if (mon_stb)
      begin
        case (mon_state_reg)
          MON_HUNT:
          begin
            if (mismatch)
              run_reg <= 3'h0;
            else if (run_reg == SYNC_MATCH_CNT - 3'h1)
            begin
              mon_state_reg <= MON_LOCKED;
              run_reg <= 3'h0;
            end
            else
              run_reg <= run_reg + 3'h1;
          end
          MON_LOCKED:
          begin
            if (!mismatch)
              run_reg <= 3'h0;
            else if (run_reg == SYNC_LOSS_CNT - 3'h1)
            begin
              mon_state_reg <= MON_HUNT;
              run_reg <= 3'h0;
            end
            else
              run_reg <= run_reg + 3'h1;
          end
          default:
            mon_state_reg <= MON_HUNT;
        endcase
      end
    end

    // Checker reference, reseeded from input while hunting
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        mon_lfsr_reg[p] <= '0;
        mon_cnt_reg <= 8'h00;
      end
      else if (sel && ram_page_select_reg == PAGE_MON_HI)
        mon_lfsr_reg[p][LFSR_W-1:LFSR_HI_LSB] <= ind_data_reg;
      else if (sel && ram_page_select_reg == PAGE_MON_LO)
        mon_lfsr_reg[p][LFSR_LO_W-1:0] <= ind_data_reg[LFSR_LO_W-1:0];
      else if (mon_stb && mismatch && mon_state_reg == MON_HUNT)
      begin
        mon_lfsr_reg[p] <= {mon_lfsr_reg[p][LFSR_W-9:0], rx_cmp};
        mon_cnt_reg <= rx_cmp + 8'h01;
      end
      else if (mon_stb)
      begin
        mon_lfsr_reg[p] <= mon_step[LFSR_W+7:8];
        mon_cnt_reg <= mon_cnt_reg + 8'h01;
      end
    end

    // Error counter with holding copy
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        err_live_reg[p] <= 16'h0000;
        err_hold_reg[p] <= 16'h0000;
      end
      else if (xfer)
      begin
        err_hold_reg[p] <= err_live_reg[p];
        err_live_reg[p] <= err_evt ? 16'h0001 : 16'h0000;
      end
      else if (err_evt && err_live_reg[p] != ERR_MAX)
        err_live_reg[p] <= err_live_reg[p] + 16'h0001;
    end

    // Generator pattern and forced error
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        gen_lfsr_reg[p] <= '0;
        gen_cnt_reg <= 8'h00;
        force_pend_reg <= 1'b0;
      end
      else
      begin
        if (sel && ram_page_select_reg == PAGE_GEN_HI)
          gen_lfsr_reg[p][LFSR_W-1:LFSR_HI_LSB] <= ind_data_reg;
        else if (gen_stb)
          gen_lfsr_reg[p] <= gen_step[LFSR_W+7:8];
        if (gen_stb)
          gen_cnt_reg <= gen_cnt_reg + 8'h01;
        if (sel && ram_page_select_reg == PAGE_GEN_CFG && ind_data_reg[GEN_FORCE_BIT])
          force_pend_reg <= 1'b1;
        else if (gen_stb)
          force_pend_reg <= 1'b0;
      end
    end

    // Generated byte for this path
    always_comb
    begin
      gen_byte[p] = gen_cfg_reg[p][GEN_SEQ_BIT] ? gen_cnt_reg : gen_step[7:0];
      gen_byte[p] = gen_byte[p] ^ {8{gen_cfg_reg[p][GEN_INV_BIT]}};
      if (force_pend_reg)
        gen_byte[p] = gen_byte[p] ^ MSB_FLIP;
    end
    assign gen_sel[p] = gen_stb;
  end

  // Outgoing frame byte, inserted or passed through
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_out_byte <= '0;
    else
    begin
      tx_out_byte.valid <= tx_in_byte.valid;
      tx_out_byte.path <= tx_in_byte.path;
      if (|gen_sel)
        tx_out_byte.data <= gen_byte[tx_in_byte.path - 4'h1];
      else
        tx_out_byte.data <= tx_in_byte.data;
    end
  end
endmodule

// *** dv/ppt_path_test_properties.sv ***
`timescale 1ns/10ps
module ppt_path_test_properties import ppt_pkg::*; #(
  parameter int NUM_PATHS = 12,
  parameter int APB_ADDR_W = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ppt_byte_t rx_byte,
  input wire ppt_byte_t tx_in_byte,
  input wire ppt_byte_t tx_out_byte,
  input wire logic [NUM_PATHS-1:0] checker_locked
);
  logic rd;
  logic wr;
  logic hit;
  // Access decode
  assign rd = psel && penable && !pwrite;
  assign wr = psel && penable && pwrite;
  assign hit = paddr inside {14'h050, 14'h200, 14'h204, 14'h218};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Register port relations
  a_idle_read_zero: assert property (!rd |-> prdata == 32'h0) else $error("prdata not idle");
  a_upper_half_zero: assert property (rd |-> prdata[31:16] == 16'h0) else $error("upper half set");
  a_busy_poll_clear: assert property (rd && paddr == 14'h200 |-> !prdata[15]) else $error("busy seen");
  a_sync_mirror: assert property (rd && paddr == 14'h218 |-> prdata[11:0] == checker_locked)
    else $error("sync mismatch");
  a_decode_error: assert property (psel && penable |-> pready && pslverr == !hit) else $error("bad response");
  a_trigger_zero: assert property (rd && paddr == 14'h050 |-> prdata == 32'h0) else $error("trigger read");
  // Stream and lock relations
  a_tx_follows: assert property ($past(presetn) |-> tx_out_byte.valid == $past(tx_in_byte.valid)
    && tx_out_byte.path == $past(tx_in_byte.path)) else $error("tx lag");
  a_lock_cause: assert property ($changed(checker_locked) |-> $past(rx_byte.valid) || $past(rx_byte.valid, 2)
    || $past(wr, 2) || $past(wr, 3)) else $error("lock changed alone");
  c_indirect: cover property (wr && paddr == 14'h200);
  c_lock: cover property ($rose(checker_locked[4]));
  c_error: cover property (pslverr);
endmodule

// *** dv/ppt_far_end.sv ***
`timescale 1ns/10ps
module ppt_far_end import ppt_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic send,
  input wire logic seq_mode,
  input wire logic invert,
  input wire logic [7:0] corrupt,
  output ppt_byte_t rx_byte
);
  logic [22:0] lfsr_reg;
  logic [22:0] lfsr_next;
  logic [7:0] count_reg;
  logic [7:0] pat;
  // Next byte, PRBS bits MSB first
  always_comb
  begin
    lfsr_next = lfsr_reg;
    pat = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      pat = {pat[6:0], lfsr_next[22] ^ lfsr_next[17]};
      lfsr_next = {lfsr_next[21:0], pat[0]};
    end
    if (seq_mode)
      pat = count_reg;
  end
  // Source on path 5; idle line toggles between inverted and true last byte
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lfsr_reg <= 23'h5a5a5a;
      count_reg <= 8'h00;
      rx_byte <= '0;
    end
    else if (send)
    begin
      lfsr_reg <= lfsr_next;
      count_reg <= count_reg + 8'h01;
      rx_byte <= '{1'h1, 4'h5, pat ^ {8{invert}} ^ corrupt};
    end
    else
      rx_byte <= '{1'h0, 4'h5, ~rx_byte.data};
endmodule

// *** dv/prbs_path_test_access_bench.sv ***
`timescale 1ns/10ps
module prbs_path_test_access_bench import ppt_pkg::*;;
  localparam logic [13:0] A_TRIG = {IDX_ACC_TRIG, 2'h0};
  localparam logic [13:0] A_ADDR = {IDX_IND_ADDR, 2'h0};
  localparam logic [13:0] A_DATA = {IDX_IND_DATA, 2'h0};
  localparam logic [13:0] A_SYNC = {IDX_SYNC_STATE, 2'h0};
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ppt_byte_t rx_byte;
  ppt_byte_t tx_in_byte = '0;
  ppt_byte_t tx_out_byte;
  logic [11:0] checker_locked;
  logic send = 1'h0;
  logic seq_mode = 1'h0;
  logic invert = 1'h0;
  logic [7:0] corrupt = 8'h00;
  ppt_byte_t outq[$];
  int fails = 0;
  int n_tests = 0;
  logic [31:0] q;
  logic e;
  logic [22:0] gs;
  ppt_path_test dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_byte, .tx_in_byte, .tx_out_byte, .checker_locked);
  ppt_far_end far_u (.pclk, .presetn, .send, .seq_mode, .invert, .corrupt, .rx_byte);
  // Clock and emitted byte capture
  always #50 pclk = ~pclk;
  always @(negedge pclk)
    if (tx_out_byte.valid === 1'h1)
      outq.push_back(tx_out_byte);
  task automatic close_out();
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      fails++;
      $display("Error %s exp %h got %h", w, x, g);
    end
  endtask
  task automatic chk_byte(input int i, input logic [3:0] p, input logic [7:0] d);
    chk("tx byte", {19'h0, 1'h1, p, d}, (i < outq.size()) ? {19'h0, outq[i]} : 32'hffffffff);
  endtask
  // One APB transfer; held until pready is sampled
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    // Wait limit reached counts as a mismatch
    if (n == 20)
      chk("pready", 32'h1, {31'h0, pready});
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic ind(input logic r, input logic [3:0] pg, input logic [3:0] p, input logic [15:0] d);
    int n;
    n = 0;
    if (!r)
      apb(1'h1, A_DATA, {16'h0, d});
    apb(1'h1, A_ADDR, {17'h0, r, 4'h0, pg, 2'h0, p});
    q = 32'h8000;
    while (q[15] !== 1'h0 && n < 20)
    begin
      apb(1'h0, A_ADDR, 32'h0);
      n++;
    end
    chk("busy", 32'h0, {31'h0, q[15]});
    if (r)
      apb(1'h0, A_DATA, 32'h0);
  endtask
  function automatic logic [7:0] nb();
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      b = {b[6:0], gs[22] ^ gs[17]};
      gs = {gs[21:0], b[0]};
    end
    return b;
  endfunction
  task automatic tx_go(input logic [3:0] p, input int n);
    outq.delete();
    repeat (n)
    begin
      tx_in_byte <= '{1'h1, p, 8'h5a};
      @(posedge pclk);
    end
    tx_in_byte <= '0;
    repeat (2) @(posedge pclk);
  endtask
  // Far end sends n bytes; every third from the second is hit, up to bad of them
  task automatic rx_go(input int n, input int bad, input logic [7:0] f);
    for (int i = 0; i < n; i++)
    begin
      send <= 1'h1;
      corrupt <= (i % 3 == 1 && i / 3 < bad) ? f : 8'h00;
      @(posedge pclk);
    end
    send <= 1'h0;
    corrupt <= 8'h00;
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_regs();
    logic [3:0] pg[5] = '{PAGE_MON_CFG, PAGE_MON_HI, PAGE_MON_LO, PAGE_GEN_CFG, PAGE_GEN_HI};
    logic [15:0] ex[5] = '{MON_CFG_MASK, 16'hffff, 16'h007f, GEN_CFG_MASK, 16'hffff};
    apb(1'h0, A_DATA, 32'h0);
    chk("data reset", 32'h0, q);
    apb(1'h1, 14'h0fc, 32'h1);
    chk("unmapped", 32'h1, {31'h0, e});
    ind(1'h0, PAGE_MON_CFG, 4'h0, 16'h0001);
    ind(1'h1, PAGE_MON_CFG, 4'h0, 16'h0);
    chk("path zero", 32'h0, q);
    ind(1'h1, 4'h3, 4'h1, 16'h0);
    chk("reserved page", 32'h0, q);
    for (int i = 0; i < 5; i++)
    begin
      ind(1'h0, pg[i], 4'hc, 16'hffff);
      ind(1'h1, pg[i], 4'hc, 16'h0);
      chk("page", {16'h0, ex[i]}, q);
      ind(1'h0, pg[i], 4'hc, 16'h0);
    end
  endtask
  task automatic t_gen();
    gs = {16'h4d2b, 7'h00};
    ind(1'h0, PAGE_GEN_HI, 4'h3, 16'h4d2b);
    ind(1'h0, PAGE_GEN_CFG, 4'h3, 16'h1000);
    tx_go(4'h3, 3);
    for (int i = 0; i < 3; i++)
      chk_byte(i, 4'h3, nb());
    ind(1'h0, PAGE_GEN_CFG, 4'h3, 16'h1002);
    tx_go(4'h3, 2);
    for (int i = 0; i < 2; i++)
      chk_byte(i, 4'h3, ~nb());
    ind(1'h0, PAGE_GEN_CFG, 4'h3, 16'h1008);
    tx_go(4'h3, 2);
    chk_byte(0, 4'h3, nb() ^ MSB_FLIP);
    chk_byte(1, 4'h3, nb());
    ind(1'h0, PAGE_GEN_CFG, 4'h3, 16'h0120);
    tx_go(4'h3, 3);
    // Seven bytes already generated on path 3
    for (int i = 0; i < 3; i++)
      chk_byte(i, 4'h3, 8'h07 + 8'(i));
    tx_go(4'h4, 2);
    chk_byte(1, 4'h4, 8'h5a);
    ind(1'h0, PAGE_GEN_CFG, 4'h3, 16'h0);
    tx_go(4'h3, 1);
    chk_byte(0, 4'h3, 8'h5a);
  endtask
  task automatic t_mon();
    rx_go(48, 0, 8'h00);
    chk("lock off", 32'h0, {31'h0, checker_locked[4]});
    ind(1'h0, PAGE_MON_CFG, 4'h5, 16'h0001);
    rx_go(48, 0, 8'h00);
    chk("lock prbs", 32'h1, {31'h0, checker_locked[4]});
    apb(1'h0, A_SYNC, 32'h0);
    chk("sync", 32'h10, q);
    apb(1'h1, A_TRIG, 32'h0);
    rx_go(9, 3, 8'hff);
    apb(1'h1, A_TRIG, 32'h0);
    ind(1'h1, PAGE_MON_ERR, 4'h5, 16'h0);
    chk("err count", 32'h3, q);
    rx_go(3, 1, 8'h01);
    ind(1'h0, PAGE_MON_ERR, 4'h5, 16'h0);
    ind(1'h1, PAGE_MON_ERR, 4'h5, 16'h0);
    chk("err copy", 32'h1, q);
    ind(1'h0, PAGE_MON_CFG, 4'h5, 16'h0009);
    chk("force_reacquire", 32'h0, {31'h0, checker_locked[4]});
    rx_go(48, 0, 8'h00);
    chk("relock", 32'h1, {31'h0, checker_locked[4]});
    invert <= 1'h1;
    ind(1'h0, PAGE_MON_CFG, 4'h5, 16'h000d);
    rx_go(48, 0, 8'h00);
    chk("lock inv", 32'h1, {31'h0, checker_locked[4]});
    invert <= 1'h0;
    seq_mode <= 1'h1;
    ind(1'h0, PAGE_MON_CFG, 4'h5, 16'h0049);
    rx_go(48, 0, 8'h00);
    chk("lock seq", 32'h1, {31'h0, checker_locked[4]});
    ind(1'h0, PAGE_MON_ERR, 4'h5, 16'h0);
    ind(1'h1, PAGE_MON_ERR, 4'h5, 16'h0);
    chk("hunt errs", 32'h0, q);
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs();
    t_gen();
    t_mon();
    close_out();
  end
  // Watchdog
  initial
  begin
    #(20000 * 100);
    fails++;
    close_out();
  end
endmodule
bind ppt_path_test ppt_path_test_properties #(.NUM_PATHS(NUM_PATHS), .APB_ADDR_W(APB_ADDR_W)) prop_u (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_byte, .tx_in_byte,
  .tx_out_byte, .checker_locked);
